// >>> rtl/pitg_pkg.sv
// constants and types for the interrupt aggregator and thermal guard
// assumes one 100 MHz clock and a synchronous active-low reset
//
// Overview of operation
// - four groups: flags, block mask, live level
// - live level unlatched; flags show latched events
// - group four has rising and falling enables
// - latched flags, blocked or not, drive one line, low
// - blocked source detects nothing; events lost
// - flag latched before blocking stays until cleared
// - asserted line means power-on; holds off sleep
// - line polarity and clear method are configurable
// - sleep line delivery selectable by configuration bit
// - pending storage keeps one last repeat event
// - pending needs two clears, other register between
// - pending off: repeat while asserted is dropped
// - new source latches at once while line asserted
// - line releases when all flags clear
// - clear-on-read clears whole read register only
// - clear-on-write clears bits written as one
// - four hot-die thresholds, hysteresis, latched event
// - shutdown level starts switch-off and records event
// - restart blocked until below hot-die threshold
// - protection on except in backup and off
// - sleep-disable bit stops shutdown watch in sleep
// - hot-die is group one bit five, both edges
package pitg_pkg;
  localparam int PITG_GROUPS = 4;
  localparam int PITG_WIDTH = 8;
  localparam int PITG_HOT_BIT = 5;
  localparam int PITG_SHUT_BIT = 7;
  localparam logic [7:0] PITG_BLOCK_RST = 8'h00;
  localparam logic [7:0] PITG_EDGE_RST = 8'hFF;
  localparam logic PITG_PEND_RST = 1'b1;
  localparam logic PITG_POL_RST = 1'b0;
  typedef enum logic [1:0] {
    PITG_PS_OFF = 2'h0,
    PITG_PS_ACTIVE = 2'h1,
    PITG_PS_SLEEP = 2'h3,
    PITG_PS_BACKUP = 2'h2
  } pitg_pstate_t;
endpackage

// >>> rtl/pitg_irq_thermal.sv
// interrupt aggregation with hot-die and thermal-shutdown events
// assumes register access decoded outside; source lines and comparator
// flags may be asynchronous to i_clk
`timescale 1ns/1ps
module pitg_irq_thermal
  import pitg_pkg::*;
#(
  parameter int GROUPS = pitg_pkg::PITG_GROUPS,
  parameter int W = pitg_pkg::PITG_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [GROUPS*W-1:0] i_src_level,
  input wire logic [3:0] i_hot_cmp,
  input wire logic i_shut_cmp,
  input wire pitg_pkg::pitg_pstate_t i_power_state,
  input wire logic i_sleep_request,
  input wire logic i_restart_request,
  input wire logic [1:0] i_hot_die_threshold_select,
  input wire logic i_thermal_guard_sleep_disable,
  input wire logic i_line_in_sleep_enable,
  input wire logic i_line_active_high,
  input wire logic i_clear_on_write,
  input wire logic i_pending_enable,
  input wire logic [GROUPS*W-1:0] i_irq_group_source_block,
  input wire logic [W-1:0] i_group4_edge_select_a,
  input wire logic [W-1:0] i_group4_edge_select_b,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic [1:0] i_acc_group,
  input wire logic [W-1:0] i_acc_wdata,
  output logic [GROUPS*W-1:0] o_irq_group_latched_flags,
  output logic [GROUPS*W-1:0] o_irq_group_live_level,
  output logic o_irq_line,
  output logic o_power_on_request,
  output logic o_sleep_allowed,
  output logic o_switch_off,
  output logic o_restart_allowed
);
  localparam int N = GROUPS * W;

  // -------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------
  logic [N-1:0] src_m_r, src_r, src_d_r;
  logic [4:0] cmp_m_r, cmp_r;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      src_m_r <= '0;
      src_r <= '0;
      src_d_r <= '0;
    end else begin
      src_m_r <= i_src_level;
      src_r <= src_m_r;
      src_d_r <= src_r;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cmp_m_r <= '0;
      cmp_r <= '0;
    end else begin
      cmp_m_r <= {i_shut_cmp, i_hot_cmp};
      cmp_r <= cmp_m_r;
    end
  end

  // -------------------------------------------------------------
  // thermal guard
  // -------------------------------------------------------------
  logic prot_on, hot_r, shut_r, hot_ev, shut_seen_r, shut_ev;
  logic in_sleep;
  assign in_sleep = (i_power_state == PITG_PS_SLEEP);
  // backup and off leave the guard idle
  assign prot_on = (i_power_state == PITG_PS_ACTIVE) ||
    (in_sleep && !i_thermal_guard_sleep_disable);
  // comparator bank carries the analog hysteresis: upper trip level
  // per threshold, released only below the lower level
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hot_r <= 1'b0;
    end else begin
      hot_r <= cmp_r[i_hot_die_threshold_select];
    end
  end
  assign hot_ev = (hot_r != cmp_r[i_hot_die_threshold_select]) &&
    (i_power_state == PITG_PS_ACTIVE || in_sleep);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      shut_seen_r <= 1'b0;
    end else begin
      shut_seen_r <= cmp_r[4] && prot_on;
    end
  end
  assign shut_ev = cmp_r[4] && prot_on && !shut_seen_r;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      shut_r <= 1'b0;
    end else if (shut_ev) begin
      shut_r <= 1'b1;
    end else if (!hot_r && i_restart_request) begin
      shut_r <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_switch_off <= 1'b0;
      o_restart_allowed <= 1'b1;
    end else begin
      o_switch_off <= cmp_r[4] && prot_on;
      o_restart_allowed <= !shut_r && !shut_ev;
    end
  end

  // -------------------------------------------------------------
  // event detection
  // -------------------------------------------------------------
  logic [N-1:0] ev, rise, fall;
  assign rise = src_r & ~src_d_r;
  assign fall = ~src_r & src_d_r;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ev
      if (gi / W == GROUPS - 1) begin : g_sel
        assign ev[gi] = (rise[gi] && i_group4_edge_select_a[gi % W]) ||
          (fall[gi] && i_group4_edge_select_b[gi % W]);
      end else if (gi == PITG_HOT_BIT) begin : g_hot
        assign ev[gi] = hot_ev;
      end else if (gi == PITG_SHUT_BIT) begin : g_shut
        assign ev[gi] = shut_ev;
      end else begin : g_any
        assign ev[gi] = rise[gi] || fall[gi];
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // status and pending
  // -------------------------------------------------------------
  logic [N-1:0] flag_r, pend_r, clr;
  logic last_valid_r;
  logic [1:0] last_grp_r;
  logic clear_ok, line_on;
  // a second clear in a row to the same group is not honoured
  assign clear_ok = i_acc_valid &&
    !(last_valid_r && last_grp_r == i_acc_group);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      last_valid_r <= 1'b0;
      last_grp_r <= 2'h0;
    end else if (i_acc_valid) begin
      last_valid_r <= 1'b1;
      last_grp_r <= i_acc_group;
    end
  end
  always_comb begin
    clr = '0;
    for (int g = 0; g < GROUPS; g++) begin
      if (clear_ok && i_acc_group == g[1:0]) begin
        if (i_clear_on_write && i_acc_write) begin
          clr[g*W +: W] = i_acc_wdata;
        end else if (!i_clear_on_write && !i_acc_write) begin
          clr[g*W +: W] = {W{1'b1}};
        end
      end
    end
  end
  assign line_on = |flag_r;
  generate
    for (gi = 0; gi < N; gi++) begin : g_flag
      logic live_ev;
      // blocked source: detection off, latched flag kept
      assign live_ev = ev[gi] && !i_irq_group_source_block[gi];
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          flag_r[gi] <= 1'b0;
          pend_r[gi] <= 1'b0;
        end else if (!flag_r[gi]) begin
          flag_r[gi] <= live_ev;
          pend_r[gi] <= 1'b0;
        end else if (clr[gi]) begin
          // pending moves up; a new event at the clear is not lost
          flag_r[gi] <= pend_r[gi] || live_ev;
          pend_r[gi] <= pend_r[gi] && live_ev && i_pending_enable;
        end else if (live_ev && i_pending_enable) begin
          pend_r[gi] <= 1'b1;
        end
        // pending off: repeat on a latched source dropped
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  logic deliver;
  assign deliver = line_on && (!in_sleep || i_line_in_sleep_enable);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_irq_group_latched_flags <= '0;
      o_irq_group_live_level <= '0;
      o_irq_line <= !PITG_POL_RST;
      o_power_on_request <= 1'b0;
      o_sleep_allowed <= 1'b0;
    end else begin
      o_irq_group_latched_flags <= flag_r;
      o_irq_group_live_level <= src_r;
      o_irq_line <= deliver ~^ i_line_active_high;
      o_power_on_request <= line_on;
      o_sleep_allowed <= i_sleep_request && !line_on;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence s_flag_clear;
    i_acc_valid && !i_clear_on_write && !i_acc_write && clear_ok;
  endsequence
  // polarity taken at the launching edge, not the checking one
  line_release_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    flag_r == '0 |=> o_irq_line == !$past(i_line_active_high))
    else $error("line not released with no flags");
  line_assert_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_r != '0 && !in_sleep) |=> o_irq_line == $past(i_line_active_high))
    else $error("line not asserted with a flag");
  sleep_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    flag_r != '0 |=> !o_sleep_allowed)
    else $error("sleep allowed with pending flag");
  read_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_flag_clear ##0 (pend_r == '0) ##0 (ev == '0) |=>
    flag_r[last_grp_r*W +: W] == '0)
    else $error("read did not clear group");
  twice_same_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_acc_valid ##1 i_acc_valid && $stable(i_acc_group)) |-> !clear_ok)
    else $error("back to back clear honoured");
  blocked_ev_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!flag_r[1] && i_irq_group_source_block[1]) |=> !flag_r[1])
    else $error("blocked source latched");
  shut_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    shut_ev |=> o_switch_off ##0 !o_restart_allowed)
    else $error("shutdown not started");
  restart_blk_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    shut_r && hot_r |=> !o_restart_allowed)
    else $error("restart allowed while hot");
  guard_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_power_state == PITG_PS_OFF) |-> !shut_ev)
    else $error("guard active in off");

  // -------------------------------------------------------------
  // checks on flags, clears and thermal outputs
  // -------------------------------------------------------------
  // a write clear only touches bits written as one
  sequence s_write_clear;
    i_acc_valid && i_clear_on_write && i_acc_write && clear_ok;
  endsequence
  // quiet cycle: nothing pending and no event racing the clear
  sequence s_quiet;
    (pend_r == '0) && (ev == '0);
  endsequence
  flags_out_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> o_irq_group_latched_flags == $past(flag_r))
    else $error("flag outputs lag the flags");
  live_out_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> o_irq_group_live_level == $past(src_r))
    else $error("live level not the synced line");
  pon_out_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> o_power_on_request == $past(line_on))
    else $error("power-on request wrong");
  new_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> ($past(ev & ~i_irq_group_source_block & ~flag_r) & ~flag_r) == '0)
    else $error("new event not latched");
  blocked_all_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> (flag_r & ~$past(flag_r) & $past(i_irq_group_source_block)) == '0)
    else $error("blocked source latched");
  pend_off_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !i_pending_enable |=> (pend_r & ~$past(pend_r)) == '0)
    else $error("pending stored while disabled");
  pend_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (pend_r & ~flag_r) == '0)
    else $error("pending without latched flag");
  pend_keep_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> ($past(clr & flag_r & pend_r) & ~flag_r) == '0)
    else $error("pending lost on first clear");
  no_access_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !clear_ok |=> ($past(flag_r) & ~flag_r) == '0)
    else $error("flag dropped without a clear");
  wrong_mode_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_acc_valid && (i_clear_on_write != i_acc_write)) |=>
    ($past(flag_r) & ~flag_r) == '0)
    else $error("access of wrong kind cleared");
  write_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    s_write_clear ##0 s_quiet |=>
    (flag_r[last_grp_r*W +: W] & $past(i_acc_wdata)) == '0)
    else $error("written ones not cleared");
  sleep_ok_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_sleep_request && !line_on) |=> o_sleep_allowed)
    else $error("sleep refused with no flags");
  sleep_mute_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (in_sleep && !i_line_in_sleep_enable) |=>
    o_irq_line == !$past(i_line_active_high))
    else $error("line driven in sleep");
  edge_none_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_group4_edge_select_a == '0 && i_group4_edge_select_b == '0) |->
    ev[N-1 -: W] == '0)
    else $error("group four event with edges off");
  hot_off_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_power_state == PITG_PS_OFF) |-> !hot_ev)
    else $error("hot-die event in off");
  hot_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (hot_ev && !i_irq_group_source_block[PITG_HOT_BIT]) |=>
    flag_r[PITG_HOT_BIT])
    else $error("hot-die flag not set");
  shut_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (shut_ev && !i_irq_group_source_block[PITG_SHUT_BIT]) |=>
    flag_r[PITG_SHUT_BIT])
    else $error("shutdown record not set");
  switch_on_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (cmp_r[4] && prot_on) |=> o_switch_off)
    else $error("switch-off not held");
  backup_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_power_state == PITG_PS_BACKUP) |=> !o_switch_off)
    else $error("switch-off in backup");
  sleep_guard_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (in_sleep && i_thermal_guard_sleep_disable) |=> !o_switch_off)
    else $error("shutdown watched in sleep");
  restart_ok_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (!shut_r && !shut_ev) |=> o_restart_allowed)
    else $error("restart blocked without shutdown");
endmodule

// >>> verification/pitg_host_model.sv
// host processor model: services the interrupt line with status accesses
// assumes the bench lets it run only while the bench itself is not accessing
`timescale 1ns/1ps
module pitg_host_model (
  input wire logic i_clk,
  input wire logic i_irq_line,
  input wire logic i_line_active_high,
  input wire logic i_clear_on_write,
  input wire logic i_service,
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic [1:0] o_acc_group,
  output logic [7:0] o_acc_wdata
);
  initial begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_group = 2'h0;
    o_acc_wdata = 8'h00;
  end
  // ----------------------------------------
  // one access, one cycle wide, off the sampling edge
  // ----------------------------------------
  task automatic access(input logic wr, input logic [1:0] grp,
                        input logic [7:0] wd);
    @(negedge i_clk);
    o_acc_valid = 1'b1;
    o_acc_write = wr;
    o_acc_group = grp;
    o_acc_wdata = wd;
    @(negedge i_clk);
    o_acc_valid = 1'b0;
    // released lines show the inverse, never a stale match
    o_acc_write = ~wr;
    o_acc_wdata = ~wd;
  endtask
  // ----------------------------------------
  // service loop: groups in turn so no two clears hit one group
  // ----------------------------------------
  always @(negedge i_clk) begin
    if (i_service && (i_irq_line === i_line_active_high)) begin
      for (int g = 0; g < 4; g++) begin
        access(i_clear_on_write, g[1:0], 8'hFF);
      end
      repeat (4) @(negedge i_clk);
    end
  end
endmodule

// >>> verification/pmu_irq_and_thermal_guard_bench.sv
// self-checking bench for the interrupt aggregator and thermal guard
// assumes group 3 rising-only setup and host model doing the clears
`timescale 1ns/1ps
module pmu_irq_and_thermal_guard_bench;
  import pitg_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] src = '0;
  logic [31:0] blk = '0;
  logic [3:0] hot = 4'h0;
  logic shut = 1'b0;
  pitg_pstate_t pst = PITG_PS_ACTIVE;
  logic sreq = 1'b0;
  logic ahigh = 1'b0;
  logic cow = 1'b0;
  logic pend = 1'b1;
  logic svc = 1'b0;
  logic [7:0] ea = 8'hFF;
  logic [7:0] eb = 8'h00;
  logic av, aw, line, pon, slp, soff, rok;
  logic [1:0] ag;
  logic [7:0] ad;
  logic [31:0] flags, live;
  int miscompares = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  pitg_irq_thermal dut (.i_clk(clk), .i_nrst(nrst), .i_src_level(src),
    .i_hot_cmp(hot), .i_shut_cmp(shut), .i_power_state(pst),
    .i_sleep_request(sreq), .i_restart_request(1'b0),
    .i_hot_die_threshold_select(2'h0),
    .i_thermal_guard_sleep_disable(1'b0), .i_line_in_sleep_enable(1'b1),
    .i_line_active_high(ahigh), .i_clear_on_write(cow),
    .i_pending_enable(pend), .i_irq_group_source_block(blk),
    .i_group4_edge_select_a(ea), .i_group4_edge_select_b(eb),
    .i_acc_valid(av), .i_acc_write(aw), .i_acc_group(ag), .i_acc_wdata(ad),
    .o_irq_group_latched_flags(flags), .o_irq_group_live_level(live),
    .o_irq_line(line), .o_power_on_request(pon), .o_sleep_allowed(slp),
    .o_switch_off(soff), .o_restart_allowed(rok));
  pitg_host_model host (.i_clk(clk), .i_irq_line(line),
    .i_line_active_high(ahigh), .i_clear_on_write(cow), .i_service(svc),
    .o_acc_valid(av), .o_acc_write(aw), .o_acc_group(ag),
    .o_acc_wdata(ad));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // drop sources, let the host clear everything, then wait it out
  task automatic cleanup;
    src = '0;
    tick(8);
    svc = 1'b1;
    tick(60);
    svc = 1'b0;
    tick(14);
    chk(flags, 32'h0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // generous: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(12);
    nrst = 1'b1;
    tick(1);
    chk(line, 1'b1);
    chk(rok, 1'b1);
    sreq = 1'b1;
    src[0] = 1'b1;
    tick(7);
    chk(flags, 32'h1);
    chk(live, 32'h1);
    chk({line, pon, slp}, 3'h2);
    src[9] = 1'b1;
    tick(7);
    chk(flags, 32'h201);
    host.access(1'b0, 2'h0, 8'h00);
    tick(3);
    chk({line, flags}, 33'h200);
    host.access(1'b0, 2'h1, 8'h00);
    tick(3);
    chk({line, slp, flags}, 34'h300000000);
    sreq = 1'b0;
    cleanup();
    blk = 32'h2;
    src[1] = 1'b1;
    tick(7);
    blk = 32'h0;
    tick(7);
    chk({line, flags}, 33'h100000000);
    src[2] = 1'b1;
    tick(7);
    blk = 32'h4;
    src[2] = 1'b0;
    tick(7);
    chk(flags, 32'h4);
    cleanup();
    blk = 32'h0;
    cow = 1'b1;
    src[3] = 1'b1;
    tick(7);
    host.access(1'b1, 2'h0, 8'hF7);
    host.access(1'b0, 2'h0, 8'h00);
    host.access(1'b0, 2'h3, 8'h00);
    tick(3);
    chk(flags, 32'h8);
    host.access(1'b1, 2'h0, 8'h08);
    tick(3);
    chk(flags, 32'h0);
    cleanup();
    cow = 1'b0;
    for (int p = 1; p >= 0; p--) begin
      pend = p[0];
      src[24] = 1'b1;
      tick(7);
      src[24] = 1'b0;
      tick(7);
      src[24] = 1'b1;
      tick(7);
      host.access(1'b0, 2'h0, 8'h00);
      host.access(1'b0, 2'h3, 8'h00);
      host.access(1'b0, 2'h3, 8'h00);
      tick(3);
      chk(flags, p ? 32'h01000000 : 32'h0);
      host.access(1'b0, 2'h0, 8'h00);
      host.access(1'b0, 2'h3, 8'h00);
      tick(3);
      chk(flags, 32'h0);
      src[24] = 1'b0;
      tick(7);
      cleanup();
    end
    ea = 8'h00;
    eb = 8'h01;
    src[24] = 1'b1;
    tick(7);
    src[24] = 1'b0;
    tick(7);
    chk(flags, 32'h01000000);
    cleanup();
    ahigh = 1'b1;
    tick(3);
    chk(line, 1'b0);
    ahigh = 1'b0;
    hot[0] = 1'b1;
    tick(7);
    chk(flags, 32'h20);
    shut = 1'b1;
    tick(7);
    chk({soff, rok, flags[7]}, 3'h5);
    complete_run();
  end
endmodule
